/* ntfc_pkg.sv */
package ntfc_pkg;

  // ==========================================================================
  // register map (byte addresses)
  localparam logic [7:0] NTFC_ADDR_FEATURE  = 8'h10;
  localparam logic [7:0] NTFC_ADDR_RINGLEN  = 8'h18;
  localparam logic [7:0] NTFC_ADDR_STATUS   = 8'h20;
  localparam logic [7:0] NTFC_ADDR_CONTROL  = 8'h24;

  // ==========================================================================
  // feature register fields
  localparam int NTFC_B_TEST     = 15;
  localparam int NTFC_B_BURSTDIS = 14;
  localparam int NTFC_B_TIMER    = 13;
  localparam int NTFC_B_POLLDIS  = 12;
  localparam int NTFC_B_MISSED_OVERFLOW_FLAG     = 9;
  localparam int NTFC_B_MISSED_OVERFLOW_MASK    = 8;
  localparam int NTFC_B_RCCO     = 5;
  localparam int NTFC_B_RCCOM    = 4;
  localparam int NTFC_B_TXB      = 3;
  localparam int NTFC_B_TXBM     = 2;
  localparam int NTFC_B_JAB      = 1;
  localparam int NTFC_B_JABBER_ERROR_MASK     = 0;

  // ring-length fields
  localparam int NTFC_TX_RING_LENGTH_CODE_LSB = 12;
  localparam int NTFC_RX_RING_LENGTH_CODE_LSB = 8;

  // control register fields
  localparam int NTFC_B_STOP = 0;
  localparam int NTFC_B_GLOBAL_INTERRUPT_ENABLE = 1;
  // status register fields
  localparam int NTFC_B_SUMMARY_INTERRUPT_FLAG    = 0;
  localparam int NTFC_B_TRANSMITTER_ON    = 1;
  localparam int NTFC_B_POLLREQ = 2;

  // ==========================================================================
  // reset values
  localparam logic [15:0] NTFC_FEATURE_RST = 16'h0115;
  localparam logic        NTFC_STOP_RST    = 1'b1;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic missedOverflow;
    logic collisionOverflow;
    logic transmitBegin;
    logic jabberDetect;
  } ntfc_event_t;

  typedef struct packed {
    logic burstCountDisable;
    logic busTimerEnable;
    logic pollEnable;
    logic testModeEnable;
  } ntfc_ctrl_t;

  typedef enum logic [1:0] {
    NTFC_IDLE   = 2'b00,
    NTFC_ACCESS = 2'b01
  } ntfc_state_t;

endpackage

/* ntfc_regs.sv */
// Behaviour
// - zero to test bit locks until reset
// - burst-count disable bit, reset clears
// - bus timer enable bit, reset clears
// - poll disable stops automatic transmit polling
// - no polling while transmitter off
// - missed overflow flag set, W1C, stop clears
// - missed overflow mask, reset sets
// - reserved feature bits read zero
// - collision overflow flag set, W1C, stop clears
// - collision overflow mask, reset sets
// - transmit begin sets its flag
// - transmit begin raises irq when unmasked
// - transmit begin flag W1C, stop clears
// - transmit begin mask, reset sets
// - jabber flag only in twisted-pair mode
// - jabber raises irq when unmasked
// - jabber flag W1C, but set wins while condition persists
// - jabber mask, reset sets
// - capture tx ring code at init
// - capture rx ring code at init
// - ring copy readable only in stop, unwritable
// - summary flag from unmasked causes, gated irq
`timescale 1ns/100ps
module ntfc_regs
  import ntfc_pkg::*;
#(
  parameter int RING_CODE_W = 4
) (
  // clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rstn,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  input  wire logic [3:0]         pstrb,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // hardware events
  input  wire ntfc_pkg::ntfc_event_t hwEvent,
  input  wire logic               twistedPairMode,
  input  wire logic               transmitterOn,
  input  wire logic               pollTick,
  // initialization capture
  input  wire logic               initLoad,
  input  wire logic [RING_CODE_W-1:0] txRingCode,
  input  wire logic [RING_CODE_W-1:0] rxRingCode,
  // control outputs
  output ntfc_pkg::ntfc_ctrl_t    ctrlOut,
  output logic                    pollRequest,
  output logic                    irqOut
);
  import ntfc_pkg::*;

  initial begin
    if (RING_CODE_W != 4) $error("ring code width must be 4");
  end

  // ==========================================================================
  // reset synchroniser
  logic rstMeta_q;
  logic rstSync_q;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end
  wire logic rstnS = rstSync_q;

  // ==========================================================================
  // apb decode
  ntfc_state_t state_q;
  wire logic access = psel && penable && (state_q == NTFC_ACCESS);
  wire logic wrLow  = access && pwrite && pstrb[0];
  wire logic wrHigh = access && pwrite && pstrb[1];
  wire logic isFeat = (paddr == NTFC_ADDR_FEATURE);
  wire logic isRing = (paddr == NTFC_ADDR_RINGLEN);
  wire logic isStat = (paddr == NTFC_ADDR_STATUS);
  wire logic isCtrl = (paddr == NTFC_ADDR_CONTROL);
  wire logic mapped = isFeat || isRing || isStat || isCtrl;

  function automatic logic w1c(input logic flag, input logic setEv, input logic clr,
                               input logic stopSet);
    // set wins over any clear
    if (setEv) return 1'b1;
    if (clr || stopSet) return 1'b0;
    return flag;
  endfunction

  always_ff @(posedge clk_sys or negedge rstnS) begin
    if (!rstnS) begin
      state_q <= NTFC_IDLE;
    end else begin
      case (state_q)
        NTFC_IDLE:   state_q <= (psel && !penable) ? NTFC_ACCESS : NTFC_IDLE;
        NTFC_ACCESS: state_q <= (psel && !penable) ? NTFC_ACCESS : NTFC_IDLE;
        default:     state_q <= NTFC_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // control register: stop and global enable
  logic stop_q;
  logic global_interrupt_enable_q;
  wire logic stopWr = wrLow && isCtrl && pwdata[NTFC_B_STOP];
  always_ff @(posedge clk_sys or negedge rstnS) begin
    if (!rstnS) begin
      stop_q <= NTFC_STOP_RST;
      global_interrupt_enable_q <= 1'b0;
    end else if (wrLow && isCtrl) begin
      stop_q <= pwdata[NTFC_B_STOP];
      global_interrupt_enable_q <= pwdata[NTFC_B_GLOBAL_INTERRUPT_ENABLE];
    end
  end

  // ==========================================================================
  // feature register
  logic [15:0] feat_q;
  logic        firstDone_q;
  logic        testLock_q;
  logic        testEn_q;
  logic        burstDis_q;
  logic        timerEn_q;
  logic        pollDis_q;
  logic        missed_overflow_flag_q;
  logic        missed_overflow_mask_q;
  logic        rcco_q;
  logic        rccom_q;
  logic        txb_q;
  logic        txbm_q;
  logic        jab_q;
  logic        jabber_error_mask_q;
  wire logic   featWrLo = wrLow && isFeat;
  wire logic   featWrHi = wrHigh && isFeat;

  always_ff @(posedge clk_sys or negedge rstnS) begin
    if (!rstnS) begin
      testEn_q    <= 1'b0;
      firstDone_q <= 1'b0;
      testLock_q  <= 1'b0;
    end else if (featWrHi) begin
      firstDone_q <= 1'b1;
      if (!pwdata[NTFC_B_TEST]) begin
        testEn_q   <= 1'b0;
        testLock_q <= 1'b1;
      end else if (!firstDone_q && !testLock_q) begin
        testEn_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstnS) begin
    if (!rstnS) begin
      burstDis_q <= NTFC_FEATURE_RST[NTFC_B_BURSTDIS];
      timerEn_q  <= NTFC_FEATURE_RST[NTFC_B_TIMER];
      pollDis_q  <= NTFC_FEATURE_RST[NTFC_B_POLLDIS];
    end else if (featWrHi) begin
      burstDis_q <= pwdata[NTFC_B_BURSTDIS];
      timerEn_q  <= pwdata[NTFC_B_TIMER];
      pollDis_q  <= pwdata[NTFC_B_POLLDIS];
    end
  end

  always_ff @(posedge clk_sys or negedge rstnS) begin
    if (!rstnS) begin
      missed_overflow_mask_q <= NTFC_FEATURE_RST[NTFC_B_MISSED_OVERFLOW_MASK];
      rccom_q <= NTFC_FEATURE_RST[NTFC_B_RCCOM];
      txbm_q  <= NTFC_FEATURE_RST[NTFC_B_TXBM];
      jabber_error_mask_q  <= NTFC_FEATURE_RST[NTFC_B_JABBER_ERROR_MASK];
    end else begin
      if (featWrHi) missed_overflow_mask_q <= pwdata[NTFC_B_MISSED_OVERFLOW_MASK];
      if (featWrLo) begin
        rccom_q <= pwdata[NTFC_B_RCCOM];
        txbm_q  <= pwdata[NTFC_B_TXBM];
        jabber_error_mask_q  <= pwdata[NTFC_B_JABBER_ERROR_MASK];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstnS) begin
    if (!rstnS) begin
      missed_overflow_flag_q <= 1'b0;
      rcco_q <= 1'b0;
      txb_q  <= 1'b0;
      jab_q  <= 1'b0;
    end else begin
      missed_overflow_flag_q <= w1c(missed_overflow_flag_q, hwEvent.missedOverflow,
                    featWrHi && pwdata[NTFC_B_MISSED_OVERFLOW_FLAG], stopWr);
      rcco_q <= w1c(rcco_q, hwEvent.collisionOverflow,
                    featWrLo && pwdata[NTFC_B_RCCO], stopWr);
      txb_q  <= w1c(txb_q, hwEvent.transmitBegin,
                    featWrLo && pwdata[NTFC_B_TXB], stopWr);
      jab_q  <= w1c(jab_q, hwEvent.jabberDetect && twistedPairMode,
                    featWrLo && pwdata[NTFC_B_JAB], stopWr);
    end
  end

  always_comb begin
    feat_q                  = 16'h0000;
    feat_q[NTFC_B_TEST]     = testEn_q;
    feat_q[NTFC_B_BURSTDIS] = burstDis_q;
    feat_q[NTFC_B_TIMER]    = timerEn_q;
    feat_q[NTFC_B_POLLDIS]  = pollDis_q;
    feat_q[NTFC_B_MISSED_OVERFLOW_FLAG]     = missed_overflow_flag_q;
    feat_q[NTFC_B_MISSED_OVERFLOW_MASK]    = missed_overflow_mask_q;
    feat_q[NTFC_B_RCCO]     = rcco_q;
    feat_q[NTFC_B_RCCOM]    = rccom_q;
    feat_q[NTFC_B_TXB]      = txb_q;
    feat_q[NTFC_B_TXBM]     = txbm_q;
    feat_q[NTFC_B_JAB]      = jab_q;
    feat_q[NTFC_B_JABBER_ERROR_MASK]     = jabber_error_mask_q;
  end

  // ==========================================================================
  // ring-length copy
  logic [RING_CODE_W-1:0] tx_ring_length_code_q;
  logic [RING_CODE_W-1:0] rx_ring_length_code_q;
  always_ff @(posedge clk_sys or negedge rstnS) begin
    if (!rstnS) begin
      tx_ring_length_code_q <= '0;
      rx_ring_length_code_q <= '0;
    end else if (initLoad) begin
      tx_ring_length_code_q <= txRingCode;
      rx_ring_length_code_q <= rxRingCode;
    end
  end

  // ==========================================================================
  // summary interrupt
  // unmasked causes
  wire logic summary =
      (feat_q[NTFC_B_MISSED_OVERFLOW_FLAG] && !feat_q[NTFC_B_MISSED_OVERFLOW_MASK]) ||
      (feat_q[NTFC_B_RCCO] && !feat_q[NTFC_B_RCCOM]) ||
      (feat_q[NTFC_B_TXB]  && !feat_q[NTFC_B_TXBM])  ||
      (feat_q[NTFC_B_JAB]  && !feat_q[NTFC_B_JABBER_ERROR_MASK]);

  always_ff @(posedge clk_sys or negedge rstnS) begin
    if (!rstnS) irqOut <= 1'b0;
    else        irqOut <= summary && global_interrupt_enable_q;
  end

  // ==========================================================================
  // polling and control outputs
  // poll gate
  always_ff @(posedge clk_sys or negedge rstnS) begin
    if (!rstnS) begin
      pollRequest <= 1'b0;
      ctrlOut     <= '0;
    end else begin
      pollRequest <= pollTick && transmitterOn && !feat_q[NTFC_B_POLLDIS] && !stop_q;
      ctrlOut.burstCountDisable <= feat_q[NTFC_B_BURSTDIS];
      ctrlOut.busTimerEnable    <= feat_q[NTFC_B_TIMER];
      ctrlOut.pollEnable        <= !feat_q[NTFC_B_POLLDIS];
      ctrlOut.testModeEnable    <= feat_q[NTFC_B_TEST];
    end
  end

  // ==========================================================================
  // read path
  logic [31:0] rdata_d;
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (isFeat) rdata_d[15:0] = feat_q;
    if (isRing && stop_q) rdata_d = {16'h0000, tx_ring_length_code_q, rx_ring_length_code_q, 8'h00};
    if (isStat) begin
      rdata_d[NTFC_B_SUMMARY_INTERRUPT_FLAG]    = summary;
      rdata_d[NTFC_B_TRANSMITTER_ON]    = transmitterOn;
      rdata_d[NTFC_B_POLLREQ] = pollRequest;
    end
    if (isCtrl) begin
      rdata_d[NTFC_B_STOP] = stop_q;
      rdata_d[NTFC_B_GLOBAL_INTERRUPT_ENABLE] = global_interrupt_enable_q;
    end
  end

  // pready is asserted in the setup cycle's following edge: zero wait
  always_ff @(posedge clk_sys or negedge rstnS) begin
    if (!rstnS) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata  <= (psel && !penable && !pwrite) ? rdata_d : 32'h0000_0000;
    end
  end

  // ==========================================================================
  // checks
  // irq follows summary
  irq_gate_a: assert property (@(posedge clk_sys) disable iff (!rstnS)
    irqOut == $past(summary && global_interrupt_enable_q)) else $error("irq mismatch");
  txb_clear_a: assert property (@(posedge clk_sys) disable iff (!rstnS)
    (featWrLo && pwdata[NTFC_B_TXB] && !hwEvent.transmitBegin) |=> !feat_q[NTFC_B_TXB])
    else $error("tx begin not cleared");
  set_wins_a: assert property (@(posedge clk_sys) disable iff (!rstnS)
    hwEvent.missedOverflow |=> feat_q[NTFC_B_MISSED_OVERFLOW_FLAG]) else $error("missed set lost");
  jab_mode_a: assert property (@(posedge clk_sys) disable iff (!rstnS)
    $rose(feat_q[NTFC_B_JAB]) |-> $past(twistedPairMode)) else $error("jabber bad mode");
  test_lock_a: assert property (@(posedge clk_sys) disable iff (!rstnS)
    testLock_q |-> !feat_q[NTFC_B_TEST]) else $error("test set after lock");
  poll_transmitter_on_a: assert property (@(posedge clk_sys) disable iff (!rstnS)
    pollRequest |-> $past(transmitterOn)) else $error("poll with tx off");
  resv_zero_a: assert property (@(posedge clk_sys) disable iff (!rstnS)
    (pready && isFeat && !pwrite) |-> prdata[7:6] == 2'b00) else $error("reserved set");
  stop_clear_a: assert property (@(posedge clk_sys) disable iff (!rstnS)
    (stopWr && !hwEvent.collisionOverflow) |=> !feat_q[NTFC_B_RCCO])
    else $error("stop kept flag");
  ring_cap_a: assert property (@(posedge clk_sys) disable iff (!rstnS)
    initLoad |=> tx_ring_length_code_q == $past(txRingCode)) else $error("ring not captured");

  irq_seen_c: cover property (@(posedge clk_sys) disable iff (!rstnS) $rose(irqOut));
  test_on_c:  cover property (@(posedge clk_sys) disable iff (!rstnS) feat_q[NTFC_B_TEST]);
  poll_c:     cover property (@(posedge clk_sys) disable iff (!rstnS) pollRequest);
  clash_c:    cover property (@(posedge clk_sys) disable iff (!rstnS)
    hwEvent.jabberDetect && twistedPairMode && featWrLo && pwdata[NTFC_B_JAB]);

endmodule // ntfc_regs

/* ntfc_regs_tb.sv */
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errorCnt++; \
  $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module ntfc_regs_tb;
  import ntfc_pkg::*;
  // ==========================================================================
  // signals
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hF;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  ntfc_event_t hwEvent = '0;
  logic        twistedPairMode = 1'b0;
  logic        transmitterOn = 1'b0;
  logic        pollTick = 1'b0;
  logic        initLoad = 1'b0;
  logic [3:0]  txRingCode = 4'h0;
  logic [3:0]  rxRingCode = 4'h0;
  ntfc_ctrl_t  ctrlOut;
  logic        pollRequest;
  logic        irqOut;
  logic [31:0] rdData;
  logic        rdErr;
  int          errorCnt = 0;
  int          comparisons = 0;
  int          cycles = 0;

  always #5 clk_sys = ~clk_sys;

  ntfc_regs ntfc_regs_inst (
    .clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hwEvent(hwEvent), .twistedPairMode(twistedPairMode),
    .transmitterOn(transmitterOn), .pollTick(pollTick), .initLoad(initLoad),
    .txRingCode(txRingCode), .rxRingCode(rxRingCode), .ctrlOut(ctrlOut),
    .pollRequest(pollRequest), .irqOut(irqOut)
  );

  // ==========================================================================
  // bus and stimulus helpers
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  // one-cycle event pulse, returns once the sampling edge has settled
  task automatic pulseEv(input logic [3:0] ev);
    @(posedge clk_sys);
    hwEvent <= ntfc_event_t'(ev);
    @(posedge clk_sys);
    hwEvent <= ntfc_event_t'(4'h0);
    #1;
  endtask

  // ==========================================================================
  // scenarios
  task automatic testTestMode();
    wr(NTFC_ADDR_FEATURE, 32'h8115);
    rd(NTFC_ADDR_FEATURE);
    `CHK(rdData, 32'h8115)
    `CHK(ctrlOut.testModeEnable, 1'b1)
    wr(NTFC_ADDR_FEATURE, 32'h0115);
    wr(NTFC_ADDR_FEATURE, 32'h8115);
    rd(NTFC_ADDR_FEATURE);
    `CHK(rdData, 32'h0115)
    `CHK(ctrlOut.testModeEnable, 1'b0)
  endtask

  task automatic testResetValues();
    rd(NTFC_ADDR_CONTROL);
    `CHK(rdData, 32'h1)
    rd(NTFC_ADDR_RINGLEN);
    `CHK(rdData, 32'h0)
    rd(8'h30);
    `CHK(rdErr, 1'b1)
    `CHK(ctrlOut, ntfc_ctrl_t'(4'b0010))
  endtask

  task automatic testFeatureBits();
    for (int b = 12; b < 15; b++) begin
      wr(NTFC_ADDR_FEATURE, 32'h0115 | (32'h1 << b));
      rd(NTFC_ADDR_FEATURE);
      `CHK(rdData, 32'h0115 | (32'h1 << b))
      `CHK(ctrlOut, ntfc_ctrl_t'({b == 14, b == 13, b != 12, 1'b0}))
    end
    wr(NTFC_ADDR_FEATURE, 32'hFFFF);
    rd(NTFC_ADDR_FEATURE);
    `CHK(rdData, 32'h7115)
    wr(NTFC_ADDR_FEATURE, 32'h0115);
  endtask

  task automatic testPoll();
    logic [2:0] cases [3];
    cases = '{3'b101, 3'b000, 3'b110};
    wr(NTFC_ADDR_CONTROL, 32'h0);
    foreach (cases[i]) begin
      wr(NTFC_ADDR_FEATURE, 32'h0115 | (32'(cases[i][1]) << NTFC_B_POLLDIS));
      @(posedge clk_sys);
      transmitterOn <= cases[i][2];
      pollTick <= 1'b1;
      @(posedge clk_sys);
      pollTick <= 1'b0;
      #1;
      `CHK(pollRequest, cases[i][0])
    end
    wr(NTFC_ADDR_FEATURE, 32'h0115);
  endtask

  task automatic testEvents();
    int pos [4];
    pos = '{NTFC_B_JAB, NTFC_B_TXB, NTFC_B_RCCO, NTFC_B_MISSED_OVERFLOW_FLAG};
    wr(NTFC_ADDR_CONTROL, 32'h2);
    wr(NTFC_ADDR_FEATURE, 32'h0);
    pulseEv(4'h1);
    rd(NTFC_ADDR_FEATURE);
    `CHK(rdData, 32'h0)
    twistedPairMode <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      pulseEv(4'h1 << i);
      @(posedge clk_sys);
      #1;
      `CHK(irqOut, 1'b1)
      rd(NTFC_ADDR_FEATURE);
      `CHK(rdData, 32'h1 << pos[i])
      wr(NTFC_ADDR_FEATURE, 32'h1 << pos[i]);
      rd(NTFC_ADDR_FEATURE);
      `CHK(rdData, 32'h0)
      `CHK(irqOut, 1'b0)
    end
    wr(NTFC_ADDR_FEATURE, 32'h0115);
    pulseEv(4'hF);
    wr(NTFC_ADDR_FEATURE, 32'h0115);
    rd(NTFC_ADDR_FEATURE);
    `CHK(rdData, 32'h033F)
    `CHK(irqOut, 1'b0)
    wr(NTFC_ADDR_FEATURE, 32'h033F);
    rd(NTFC_ADDR_FEATURE);
    `CHK(rdData, 32'h0115)
    wr(NTFC_ADDR_FEATURE, 32'h0);
    wr(NTFC_ADDR_CONTROL, 32'h0);
    pulseEv(4'hF);
    rd(NTFC_ADDR_STATUS);
    `CHK(rdData[NTFC_B_SUMMARY_INTERRUPT_FLAG], 1'b1)
    `CHK(irqOut, 1'b0)
    wr(NTFC_ADDR_CONTROL, 32'h1);
    rd(NTFC_ADDR_FEATURE);
    `CHK(rdData, 32'h0)
    wr(NTFC_ADDR_FEATURE, 32'h0115);
    rd(NTFC_ADDR_FEATURE);
    `CHK(rdData, 32'h0115)
  endtask

  task automatic testRing();
    wr(NTFC_ADDR_CONTROL, 32'h1);
    @(posedge clk_sys);
    initLoad <= 1'b1;
    txRingCode <= 4'hA;
    rxRingCode <= 4'h5;
    @(posedge clk_sys);
    initLoad <= 1'b0;
    rd(NTFC_ADDR_RINGLEN);
    `CHK(rdData, 32'hA500)
    wr(NTFC_ADDR_RINGLEN, 32'hFFFF);
    rd(NTFC_ADDR_RINGLEN);
    `CHK(rdData, 32'hA500)
    wr(NTFC_ADDR_CONTROL, 32'h0);
    rd(NTFC_ADDR_RINGLEN);
    `CHK(rdData, 32'h0)
  endtask

  // ==========================================================================
  // verdict and timeout
  task automatic endSim();
    $display("comparisons %0d errors %0d", comparisons, errorCnt);
    if (errorCnt == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      errorCnt++;
      endSim();
    end
  end

  initial begin
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    testTestMode();
    testResetValues();
    testFeatureBits();
    testPoll();
    testEvents();
    testRing();
    endSim();
  end
endmodule // ntfc_regs_tb
